// file: sim/ssr_stage_setup_tb.sv
/*
  Self-checking testbench for the stage setup register bank.
  Assumes the Avalon-MM timing and the stage port latency of the design.
*/
`timescale 1ns/100ps
module ssr_stage_setup_tb
  import ssr_pkg::*;
;
  // Clock, reset and bus.
  logic        core_clk;
  logic        reset_n;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  // Stage port.
  logic [3:0]  stage_select;
  logic        cfg_valid;
  logic [27:0] input_routing_field;
  logic        low_side_offset_off;
  logic        high_side_offset_off;
  logic [6:0]  low_side_offset_value;
  logic        low_side_offset_steer;
  logic [6:0]  high_side_offset_value;
  logic        high_side_offset_steer;
  logic [3:0]  low_side_touch_ratio;
  logic [2:0]  low_side_peak_level;
  logic [3:0]  high_side_touch_ratio;
  logic [2:0]  high_side_peak_level;
  // Bench state.
  logic [15:0] mdl [4*SSR_STAGES];
  logic        mdl_en;
  logic        mdl_clamp;
  logic [31:0] rq [$];
  logic [60:0] sq [$];
  logic        stage_req;
  logic        req_d1;
  logic        req_d2;
  logic [60:0] obs;
  int          err_total;
  int          n_compared;

  ssr_stage_setup u_dut (
    .core_clk              (core_clk),
    .reset_n               (reset_n),
    .avs_address           (avs_address),
    .avs_read              (avs_read),
    .avs_write             (avs_write),
    .avs_writedata         (avs_writedata),
    .avs_byteenable        (avs_byteenable),
    .avs_readdata          (avs_readdata),
    .avs_waitrequest       (avs_waitrequest),
    .stage_select          (stage_select),
    .cfg_valid             (cfg_valid),
    .input_routing_field   (input_routing_field),
    .low_side_offset_off   (low_side_offset_off),
    .high_side_offset_off  (high_side_offset_off),
    .low_side_offset_value (low_side_offset_value),
    .low_side_offset_steer (low_side_offset_steer),
    .high_side_offset_value(high_side_offset_value),
    .high_side_offset_steer(high_side_offset_steer),
    .low_side_touch_ratio  (low_side_touch_ratio),
    .low_side_peak_level   (low_side_peak_level),
    .high_side_touch_ratio (high_side_touch_ratio),
    .high_side_peak_level  (high_side_peak_level)
  );

  assign obs = {cfg_valid, input_routing_field, low_side_offset_off,
                high_side_offset_off, low_side_offset_value,
                low_side_offset_steer, high_side_offset_value,
                high_side_offset_steer, low_side_touch_ratio,
                low_side_peak_level, high_side_touch_ratio,
                high_side_peak_level};

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic check(input string what, input logic [63:0] seen,
                       input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  function automatic logic [31:0] exp_word(input logic [7:0] a);
    if (a < 4 * SSR_STAGES)
      return {16'h0000, mdl[a]};
    if (a == SSR_CTRL_INDEX)
      return {31'h0, mdl_en};
    if (a == SSR_STATUS_INDEX)
      return {23'h0, mdl_clamp, 3'h0, mdl_en, stage_select};
    return 32'h0000_0000;
  endfunction : exp_word

  // Parked fields unless the port is enabled and the stage exists.
  function automatic logic [60:0] exp_stage(input int s);
    logic [15:0] lo, up, of, se;
    logic [2:0]  lp, hp;
    if (!mdl_en || s >= SSR_STAGES)
      return {1'b0, 28'h0, 2'b11, 30'h0};
    lo = mdl[4*s];
    up = mdl[4*s+1];
    of = mdl[4*s+2];
    se = mdl[4*s+3];
    lp = (se[6:4] > SSR_PEAK_MAX) ? SSR_PEAK_MAX : se[6:4];
    hp = (se[14:12] > SSR_PEAK_MAX) ? SSR_PEAK_MAX : se[14:12];
    return {1'b1, up[13:0], lo[13:0], up[14], up[15], of[6:0], of[7],
            of[14:8], of[15], se[3:0], lp, se[11:8], hp};
  endfunction : exp_stage

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [15:0] d, input logic [3:0] be);
    int          n;
    logic [15:0] nv;
    n = 0;
    @(posedge core_clk);
    avs_address    <= a;
    avs_write      <= wr;
    avs_read       <= !wr;
    avs_writedata  <= {16'($urandom), d};
    avs_byteenable <= be;
    if (!wr)
      rq.push_back(exp_word(a));
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) begin
      err_total++;
      $display("[FAIL] waitrequest expected low seen high");
    end
    if (wr && a < 4 * SSR_STAGES) begin
      nv = mdl[a];
      if (be[0])
        nv[7:0] = d[7:0];
      if (be[1])
        nv[15:8] = d[15:8];
      mdl[a] = nv & SSR_LANE_MASK[a[1:0]];
    end
    if (wr && a == SSR_CTRL_INDEX && be[0])
      mdl_en = d[0];
    if (wr && a == SSR_STATUS_INDEX && be[1] && d[8])
      mdl_clamp = 1'b0;
  endtask : bus

  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 16'h0000, 4'hF);
  endtask : rd

  task automatic stg(input int s);
    @(posedge core_clk);
    stage_select <= 4'(s);
    stage_req    <= 1'b1;
    sq.push_back(exp_stage(s));
    if (mdl_en && s < SSR_STAGES && (mdl[4*s+3][6:4] > SSR_PEAK_MAX ||
                                     mdl[4*s+3][14:12] > SSR_PEAK_MAX))
      mdl_clamp = 1'b1;
    @(posedge core_clk);
    stage_req <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask : stg

  // Result watcher: bus answers and the stage port two cycles on.
  always @(posedge core_clk) begin
    req_d1 <= stage_req;
    req_d2 <= req_d1;
    if (avs_read && avs_waitrequest === 1'b0 && rq.size() > 0)
      check("readdata", {32'h0, avs_readdata}, {32'h0, rq.pop_front()});
    if (req_d2 && sq.size() > 0)
      check("stage", {3'h0, obs}, {3'h0, sq.pop_front()});
  end

  task automatic do_reset();
    reset_n <= 1'b0;
    for (int i = 0; i < 4 * SSR_STAGES; i++)
      mdl[i] = 16'h0000;
    mdl_en = SSR_CTRL_ENABLE_RESET;
    mdl_clamp = 1'b0;
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask : do_reset

  initial begin
    reset_n = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    stage_select = 4'h0;
    stage_req = 1'b0;
    err_total = 0;
    n_compared = 0;
    void'($urandom(32'he524));
    do_reset();
    for (int i = 0; i < 4 * SSR_STAGES; i += 5)
      rd(8'(i));
    rd(SSR_CTRL_INDEX);
    stg(0);
    // Random contents in every stage, then read all back.
    for (int i = 0; i < 4 * SSR_STAGES; i++)
      bus(1'b1, 8'(i), 16'($urandom), 4'h3);
    for (int i = 0; i < 4 * SSR_STAGES; i++)
      rd(8'(i));
    // Byte lanes one at a time and none.
    bus(1'b1, 8'h05, 16'h1234, 4'h1);
    rd(8'h05);
    bus(1'b1, 8'h05, 16'hABCD, 4'h2);
    rd(8'h05);
    bus(1'b1, 8'h05, 16'hFFFF, 4'hC);
    rd(8'h05);
    // Unmapped places ignore writes and read zero.
    bus(1'b1, 8'h32, 16'hFFFF, 4'h3);
    bus(1'b1, 8'hFF, 16'hFFFF, 4'h3);
    rd(8'h32);
    rd(8'hFF);
    // Enable the stage port and walk every select value.
    bus(1'b1, SSR_CTRL_INDEX, 16'h0001, 4'h1);
    rd(SSR_CTRL_INDEX);
    for (int s = 0; s < 16; s++)
      stg(s);
    // Every routing code in every field, peak codes 4 to 7.
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, 8'h2C, {8{2'(c)}}, 4'h3);
      bus(1'b1, 8'h2D, {8{2'(3 - c)}}, 4'h3);
      bus(1'b1, 8'h2F, {1'b0, 3'(c + 4), 4'(c), 1'b0, 3'(7 - c),
                        4'(15 - c)}, 4'h3);
      rd(8'h2F);
      stg(11);
    end
    bus(1'b1, SSR_CTRL_INDEX, 16'h0000, 4'h1);
    stg(3);
    // Status shows the clamp flag, then a write of one clears it.
    rd(SSR_STATUS_INDEX);
    bus(1'b1, SSR_STATUS_INDEX, 16'h0100, 4'h2);
    rd(SSR_STATUS_INDEX);
    // A second reset clears everything again.
    do_reset();
    rd(8'h2D);
    rd(8'h2F);
    rd(SSR_CTRL_INDEX);
    rd(SSR_STATUS_INDEX);
    stg(11);
    repeat (4) @(posedge core_clk);
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    $display("[FAIL] run expected to finish seen timeout");
    stop_test();
  end

endmodule : ssr_stage_setup_tb

// file: src/ssr_mem_if.sv
/*
  Carrier between the register bank control and its stage memory.
  Assumes both ends share one clock.
*/
`timescale 1ns/100ps
interface ssr_mem_if #(parameter int STAGES = 12);
  localparam int SW = (STAGES > 1) ? $clog2(STAGES) : 1;
  logic          wr_en;
  logic [SW-1:0] wr_stage;
  logic [1:0]    wr_lane;
  logic [15:0]   wr_data;
  logic [SW-1:0] a_stage;
  logic [1:0]    a_lane;
  logic [15:0]   a_data;
  logic [SW-1:0] b_stage;
  logic [63:0]   b_data;

  modport mem (input wr_en, wr_stage, wr_lane, wr_data, a_stage, a_lane,
               b_stage, output a_data, b_data);
  modport ctl (output wr_en, wr_stage, wr_lane, wr_data, a_stage, a_lane,
               b_stage, input a_data, b_data);
endinterface : ssr_mem_if

// file: src/ssr_pkg.sv
/*
  Constants, field layout and types shared by the stage setup register bank.
  Assumes one 16-bit word per register, four registers per stage.
*/
package ssr_pkg;

  localparam int SSR_STAGES   = 12;
  localparam int SSR_LANES    = 4;
  localparam int SSR_WORD_W   = 16;
  localparam int SSR_ADDR_W   = 8;

  // Lane of each register within a stage; word index = stage * 4 + lane.
  localparam logic [1:0] SSR_LANE_LOW_ROUTE  = 2'h0;
  localparam logic [1:0] SSR_LANE_HIGH_ROUTE = 2'h1;
  localparam logic [1:0] SSR_LANE_OFFSET     = 2'h2;
  localparam logic [1:0] SSR_LANE_SENS       = 2'h3;

  // Writable bits of each lane; the others read back as zero.
  localparam logic [15:0] SSR_LANE_MASK [SSR_LANES] =
    '{16'h3FFF, 16'hFFFF, 16'hFFFF, 16'h7F7F};
  localparam logic [15:0] SSR_WORD_RESET = 16'h0000;

  // Extra registers beyond the stage space.
  localparam logic [7:0] SSR_CTRL_INDEX   = 8'h30;
  localparam logic [7:0] SSR_STATUS_INDEX = 8'h31;
  localparam int         SSR_CTRL_ENABLE_BIT   = 0;
  localparam int         SSR_STATUS_ENABLE_BIT = 4;
  localparam int         SSR_STATUS_CLAMP_BIT  = 8;
  localparam logic       SSR_CTRL_ENABLE_RESET = 1'b0;

  // Routing codes for one sensor input.
  localparam logic [1:0] SSR_ROUTE_ISOLATE  = 2'h0;
  localparam logic [1:0] SSR_ROUTE_NEGATIVE = 2'h1;
  localparam logic [1:0] SSR_ROUTE_POSITIVE = 2'h2;
  localparam logic [1:0] SSR_ROUTE_BIAS     = 2'h3;

  // Highest defined peak-detect code (90 percent).
  localparam logic [2:0] SSR_PEAK_MAX = 3'h5;

  typedef struct packed {
    logic [27:0] route;
    logic        low_off;
    logic        high_off;
    logic [6:0]  low_val;
    logic        low_steer;
    logic [6:0]  high_val;
    logic        high_steer;
    logic [3:0]  low_ratio;
    logic [2:0]  low_peak;
    logic [3:0]  high_ratio;
    logic [2:0]  high_peak;
  } ssr_stage_cfg_t;

  typedef enum logic [1:0] {
    SSR_BUS_IDLE,
    SSR_BUS_FETCH,
    SSR_BUS_ACK
  } ssr_bus_state_t;

endpackage : ssr_pkg

// file: src/ssr_stage_decode.sv
/*
  Splits one stage entry into its fields, or parks them when not live.
  Assumes lane 0 lower routing, 1 upper routing, 2 offset, 3 sensitivity.
*/
`timescale 1ns/100ps
module ssr_stage_decode
  import ssr_pkg::*;
(
  // Stage entry.
  input  wire logic        live,
  input  wire logic [63:0] stage_word,
  // Decoded fields.
  output ssr_stage_cfg_t   cfg,
  output logic             clamped
);

  logic [15:0] lo;
  logic [15:0] hi;
  logic [15:0] ofs;
  logic [15:0] sens;

  assign lo   = stage_word[15:0];
  assign hi   = stage_word[31:16];
  assign ofs  = stage_word[47:32];
  assign sens = stage_word[63:48];

  always_comb begin
    cfg          = '0;
    cfg.low_off  = 1'b1;
    cfg.high_off = 1'b1;
    clamped      = 1'b0;
    if (live) begin
      cfg.route      = {hi[13:0], lo[13:0]};
      cfg.low_off    = hi[14];
      cfg.high_off   = hi[15];
      cfg.low_val    = ofs[6:0];
      cfg.low_steer  = ofs[7];
      cfg.high_val   = ofs[14:8];
      cfg.high_steer = ofs[15];
      cfg.low_ratio  = sens[3:0];
      cfg.high_ratio = sens[11:8];
      cfg.low_peak   = (sens[6:4] > SSR_PEAK_MAX) ? SSR_PEAK_MAX
                                                 : sens[6:4];
      cfg.high_peak  = (sens[14:12] > SSR_PEAK_MAX) ? SSR_PEAK_MAX
                                                   : sens[14:12];
      clamped = (sens[6:4] > SSR_PEAK_MAX) ||
                (sens[14:12] > SSR_PEAK_MAX);
    end
  end

endmodule : ssr_stage_decode

// file: src/ssr_stage_mem.sv
/*
  Stage memory: one 64-bit entry of four 16-bit words per stage.
  Port A reads one word for the bus, port B a whole stage; both registered.
  Assumes the writer has already applied the lane masks.
*/
`timescale 1ns/100ps
module ssr_stage_mem
  import ssr_pkg::*;
#(
  parameter int STAGES = 12
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Memory port.
  ssr_mem_if.mem   mem
);
  // A single stage still needs a one-bit stage index.
  localparam int SW = (STAGES > 1) ? $clog2(STAGES) : 1;

  logic [63:0] store [STAGES];

  if (STAGES < 1 || STAGES > 16) begin : g_check
    $error("ssr_stage_mem: STAGES must be 1 to 16");
  end

  for (genvar s = 0; s < STAGES; s++) begin : g_entry
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        store[s] <= {SSR_LANES{SSR_WORD_RESET}};
      end else if (mem.wr_en && mem.wr_stage == SW'(s)) begin
        store[s][{mem.wr_lane, 4'h0} +: 16] <= mem.wr_data;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem.a_data <= 16'h0000;
    end else if (mem.a_stage < STAGES) begin
      mem.a_data <= store[mem.a_stage][{mem.a_lane, 4'h0} +: 16];
    end else begin
      mem.a_data <= 16'h0000;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem.b_data <= 64'h0000000000000000;
    end else if (mem.b_stage < STAGES) begin
      mem.b_data <= store[mem.b_stage];
    end else begin
      mem.b_data <= 64'h0000000000000000;
    end
  end

endmodule : ssr_stage_mem

// file: src/ssr_stage_setup.sv
/*
  Per-stage setup register bank of a capacitance converter with an
  Avalon-MM slave for software and a stage port for the sequencer.
  Assumes the sequencer drives stage_select from core_clk logic.
*/
// Behaviour
// - Inputs eleven to thirteen take 2-bit routing fields at upper bits 13:8.
// - Upper routing bit 14 set disables the low-side front-end offset.
// - Upper routing bit 15 set disables the high-side front-end offset.
// - Offset bits 6:0 hold the low-side offset magnitude, 0.16 pF steps.
// - Offset bit 7 moves the low-side offset to the positive input.
// - Offset bits 14:8 hold the high-side offset magnitude, 0.16 pF steps.
// - Offset bit 15 moves the high-side offset to the negative input.
// - Sensitivity bits 3:0 select one of sixteen low-side touch ratios.
// - Sensitivity bits 6:4 select the low-side peak level, 40 to 90 percent.
// - Sensitivity bits 11:8 select the high-side touch ratio.
// - Sensitivity bits 14:12 select the high-side peak level.
// - Each of twelve stages has its own four setup registers.
// - Lower routing register holds the low inputs from bits 1:0 upward.
// - Inputs seven to ten occupy upper routing bits 7:0.
`timescale 1ns/100ps
module ssr_stage_setup
  import ssr_pkg::*;
#(
  parameter int STAGES = SSR_STAGES
) (
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // Avalon-MM slave.
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Sequencer stage port.
  input  wire logic [3:0]  stage_select,
  output logic             cfg_valid,
  output logic [27:0]      input_routing_field,
  output logic             low_side_offset_off,
  output logic             high_side_offset_off,
  output logic [6:0]       low_side_offset_value,
  output logic             low_side_offset_steer,
  output logic [6:0]       high_side_offset_value,
  output logic             high_side_offset_steer,
  output logic [3:0]       low_side_touch_ratio,
  output logic [2:0]       low_side_peak_level,
  output logic [3:0]       high_side_touch_ratio,
  output logic [2:0]       high_side_peak_level
);

  // A single stage still needs a one-bit stage index.
  localparam int SW = (STAGES > 1) ? $clog2(STAGES) : 1;

  if (STAGES < 1 || STAGES > 16 || STAGES * SSR_LANES > SSR_CTRL_INDEX)
  begin : g_check
    $error("ssr_stage_setup: STAGES out of range");
  end

  // Reset release through two flip-flops.
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  ssr_mem_if #(.STAGES(STAGES)) mem_if ();

  ssr_stage_mem #(.STAGES(STAGES)) u_mem (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .mem      (mem_if.mem)
  );

  // Address decode.
  logic       in_stage_space;
  logic [1:0] lane;

  assign lane           = avs_address[1:0];
  assign in_stage_space = avs_address < STAGES * SSR_LANES;

  // Bus sequence: take request, fetch word, answer and commit write.
  ssr_bus_state_t bus_state;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_state <= SSR_BUS_IDLE;
    end else begin
      case (bus_state)
        SSR_BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_state <= SSR_BUS_FETCH;
          end
        end
        SSR_BUS_FETCH: bus_state <= SSR_BUS_ACK;
        SSR_BUS_ACK:   bus_state <= SSR_BUS_IDLE;
        default:       bus_state <= SSR_BUS_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= (bus_state != SSR_BUS_FETCH);
    end
  end

  // Write path: byte lanes merged over the fetched word, then masked.
  logic        commit;
  logic [15:0] merged;

  assign commit = (bus_state == SSR_BUS_ACK) && avs_write;
  assign merged = {avs_byteenable[1] ? avs_writedata[15:8]
                                     : mem_if.a_data[15:8],
                   avs_byteenable[0] ? avs_writedata[7:0]
                                     : mem_if.a_data[7:0]};

  assign mem_if.wr_en    = commit && in_stage_space;
  assign mem_if.wr_stage = SW'(avs_address[7:2]);
  assign mem_if.wr_lane  = lane;
  assign mem_if.wr_data  = merged & SSR_LANE_MASK[lane];
  assign mem_if.a_stage  = SW'(avs_address[7:2]);
  assign mem_if.a_lane   = lane;

  // Control register: enable gates the stage port.
  logic ctrl_enable;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_enable <= SSR_CTRL_ENABLE_RESET;
    end else if (commit && avs_address == SSR_CTRL_INDEX &&
                 avs_byteenable[0]) begin
      ctrl_enable <= avs_writedata[SSR_CTRL_ENABLE_BIT];
    end
  end

  // Stage port: memory read, then decode into the output flops.
  logic       stage_hit;
  logic [3:0] stage_q;
  logic       dec_clamped;
  ssr_stage_cfg_t dec_cfg;
  ssr_stage_cfg_t cfg_q;

  assign mem_if.b_stage = SW'(stage_select);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_hit <= 1'b0;
      stage_q   <= 4'h0;
    end else begin
      stage_hit <= ctrl_enable && (stage_select < STAGES);
      stage_q   <= stage_select;
    end
  end

  ssr_stage_decode u_dec (
    .live       (stage_hit),
    .stage_word (mem_if.b_data),
    .cfg        (dec_cfg),
    .clamped    (dec_clamped)
  );

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q          <= '0;
      cfg_q.low_off  <= 1'b1;
      cfg_q.high_off <= 1'b1;
      cfg_valid      <= 1'b0;
    end else begin
      cfg_q     <= dec_cfg;
      cfg_valid <= stage_hit;
    end
  end

  assign input_routing_field    = cfg_q.route;
  assign low_side_offset_off    = cfg_q.low_off;
  assign high_side_offset_off   = cfg_q.high_off;
  assign low_side_offset_value  = cfg_q.low_val;
  assign low_side_offset_steer  = cfg_q.low_steer;
  assign high_side_offset_value = cfg_q.high_val;
  assign high_side_offset_steer = cfg_q.high_steer;
  assign low_side_touch_ratio   = cfg_q.low_ratio;
  assign low_side_peak_level    = cfg_q.low_peak;
  assign high_side_touch_ratio  = cfg_q.high_ratio;
  assign high_side_peak_level   = cfg_q.high_peak;

  // Sticky flag: a live stage used an undefined peak code. A new event
  // wins over a write-one clear in the same cycle.
  logic clamp_seen;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clamp_seen <= 1'b0;
    end else if (stage_hit && dec_clamped) begin
      clamp_seen <= 1'b1;
    end else if (commit && avs_address == SSR_STATUS_INDEX &&
                 avs_byteenable[1] &&
                 avs_writedata[SSR_STATUS_CLAMP_BIT]) begin
      clamp_seen <= 1'b0;
    end
  end

  // Read data, registered one cycle before the answer.
  logic [31:0] next_readdata;

  always_comb begin
    next_readdata = 32'h00000000;
    if (in_stage_space) begin
      next_readdata[15:0] = mem_if.a_data;
    end else if (avs_address == SSR_CTRL_INDEX) begin
      next_readdata[SSR_CTRL_ENABLE_BIT] = ctrl_enable;
    end else if (avs_address == SSR_STATUS_INDEX) begin
      next_readdata[3:0]                   = stage_q;
      next_readdata[SSR_STATUS_ENABLE_BIT] = ctrl_enable;
      next_readdata[SSR_STATUS_CLAMP_BIT]  = clamp_seen;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h00000000;
    end else if (bus_state == SSR_BUS_FETCH) begin
      avs_readdata <= next_readdata;
    end
  end

  // Checks on the stage port and the bus answer.
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  property p_route_high;
    cfg_valid |-> input_routing_field[27:22] == $past(mem_if.b_data[29:24]);
  endproperty
  a_route_high: assert property (p_route_high)
    else $error("routing of inputs eleven to thirteen wrong");

  property p_route_low;
    cfg_valid |-> input_routing_field[13:0] == $past(mem_if.b_data[13:0]);
  endproperty
  a_route_low: assert property (p_route_low)
    else $error("lower routing fields wrong");

  property p_route_mid;
    cfg_valid |-> input_routing_field[21:14] == $past(mem_if.b_data[23:16]);
  endproperty
  a_route_mid: assert property (p_route_mid)
    else $error("routing of inputs seven to ten wrong");

  property p_low_off;
    cfg_valid |-> low_side_offset_off == $past(mem_if.b_data[30]);
  endproperty
  a_low_off: assert property (p_low_off)
    else $error("low-side offset disable wrong");

  property p_high_off;
    cfg_valid |-> high_side_offset_off == $past(mem_if.b_data[31]);
  endproperty
  a_high_off: assert property (p_high_off)
    else $error("high-side offset disable wrong");

  property p_low_offset;
    cfg_valid |-> {low_side_offset_steer, low_side_offset_value} ==
                  $past(mem_if.b_data[39:32]);
  endproperty
  a_low_offset: assert property (p_low_offset)
    else $error("low-side offset value or steer wrong");

  property p_high_offset;
    cfg_valid |-> {high_side_offset_steer, high_side_offset_value} ==
                  $past(mem_if.b_data[47:40]);
  endproperty
  a_high_offset: assert property (p_high_offset)
    else $error("high-side offset value or steer wrong");

  property p_ratio;
    cfg_valid |-> low_side_touch_ratio == $past(mem_if.b_data[51:48]) &&
                  high_side_touch_ratio == $past(mem_if.b_data[59:56]);
  endproperty
  a_ratio: assert property (p_ratio)
    else $error("touch ratio wrong");

  property p_peak;
    cfg_valid |-> low_side_peak_level <= 3'h5 &&
      high_side_peak_level <= 3'h5 &&
      ($past(mem_if.b_data[54:52]) > 3'h5 ||
       low_side_peak_level == $past(mem_if.b_data[54:52])) &&
      ($past(mem_if.b_data[62:60]) > 3'h5 ||
       high_side_peak_level == $past(mem_if.b_data[62:60]));
  endproperty
  a_peak: assert property (p_peak)
    else $error("peak level wrong or above 90 percent");

  property p_stage_range;
    (stage_select >= STAGES || !ctrl_enable) |-> ##2 !cfg_valid &&
      input_routing_field == 28'h0000000 && low_side_offset_off;
  endproperty
  a_stage_range: assert property (p_stage_range)
    else $error("stage port live for missing stage or while disabled");

  property p_unused_zero;
    (bus_state == SSR_BUS_ACK && $past(in_stage_space)) |->
      avs_readdata[31:16] == 16'h0000 &&
      (avs_address[1:0] != 2'h0 || avs_readdata[15:14] == 2'h0) &&
      (avs_address[1:0] != 2'h3 || (avs_readdata[7] == 1'b0 &&
                                     avs_readdata[15] == 1'b0));
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused bit read back as one");

  property p_bus_answer;
    (bus_state == SSR_BUS_IDLE && (avs_read || avs_write)) |->
      avs_waitrequest ##1 avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus answer not in third cycle");

  property p_clamp_set;
    (stage_hit && dec_clamped) |=> clamp_seen;
  endproperty
  a_clamp_set: assert property (p_clamp_set)
    else $error("peak clamp flag not set by a live clamped stage");

  property p_answer_one_cycle;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_answer_one_cycle: assert property (p_answer_one_cycle)
    else $error("waitrequest low for more than one cycle");

  c_read_stage: cover property (bus_state == SSR_BUS_ACK && avs_read &&
                                in_stage_space);
  c_write_sens: cover property (commit && in_stage_space &&
                                lane == SSR_LANE_SENS);
  c_clamp: cover property (stage_hit && dec_clamped);
  c_live: cover property (cfg_valid && stage_q == 4'hB);

endmodule : ssr_stage_setup
